// ===== src/input_select_eq_control.sv
//----------------------------------------------------------------------
// Purpose: control registers for serial input choice and equalizer
// Assumes: register port comes from the local control slave, one
//          access per cycle; pins synchronous to mclk
// Notes:   power_down_pin low holds every register at reset value except the tracker's lock history
//----------------------------------------------------------------------
// Behaviour
// - impedance field of second input resets zero, stores any written code, e.g. 70
// - override clear: active input follows the external select pin
// - override set: active input follows channel-select bit 6
// - channel-select 0 picks input 0, 1 picks input 1, resets 0
// - bypass set: adaption stops, manual equalizer level applied
// - bits 7:4 of level register read applied level, zero after reset
// - loss of lock restarts adaptive equalizer, and its readback when bypass is clear
`timescale 1ns/1ps
module input_select_eq_control
  import sel_eq_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic                   power_down_pin,
  input  wire logic                   select_pin,
  input  wire sel_eq_pkg::reg_req_s   reg_req,
  input  wire logic [3:0]             manual_eq_level,
  input  wire sel_eq_pkg::eq_status_s adaptive_status,
  output logic [7:0]                  rd_data_q,
  output logic                        rd_valid_q,
  output logic                        active_channel_q,
  output logic [7:0]                  second_serial_input_impedance_q,
  output logic [1:0]                  back_control_link_term_q,
  output logic                        eq_bypass_q,
  output logic [3:0]                  eq_level_q,
  output logic                        eq_restart_q
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic       sel_ovr_q;
  logic       sel_ovr_d;
  logic       sel_chan_q;
  logic       sel_chan_d;
  logic       eq_bypass_d;
  logic [7:0] impedance_d;
  logic [1:0] term_d;
  logic       active_channel_d;
  logic [7:0] rd_data_d;
  logic       rd_valid_d;
  logic       held_down;

  // pin is taken as synchronous; the host owns its sequencing
  assign held_down = !power_down_pin;

  always_comb
  begin
    sel_ovr_d   = sel_ovr_q;
    sel_chan_d  = sel_chan_q;
    eq_bypass_d = eq_bypass_q;
    impedance_d = second_serial_input_impedance_q;
    term_d      = back_control_link_term_q;
    rd_data_d   = READ_ZERO;
    rd_valid_d  = reg_req.rd && !held_down;
    if (held_down)
    begin
      sel_ovr_d   = SEL_OVR_RST;
      sel_chan_d  = SEL_CHAN_RST;
      eq_bypass_d = EQ_BYPASS_RST;
      impedance_d = IMPEDANCE_RST;
      term_d      = TERM_RST;
    end
    else
    begin
      if (reg_req.wr)
      begin
        // only named fields are stored; other bits fall away
        unique case (reg_req.addr)
          OFF_CTRL_CHAN_TUNING_IN1: term_d = reg_req.wdata[TERM_MSB:TERM_LSB];
          OFF_FWD_CHAN_IMPEDANCE:   impedance_d = reg_req.wdata;
          OFF_INPUT_SELECTION:
          begin
            sel_ovr_d  = reg_req.wdata[SEL_OVR_BIT];
            sel_chan_d = reg_req.wdata[SEL_CHAN_BIT];
          end
          OFF_EQ_TEST_MODE:         eq_bypass_d = reg_req.wdata[EQ_BYPASS_BIT];
          default:                  ;
        endcase
      end
      if (reg_req.rd)
      begin
        unique case (reg_req.addr)
          OFF_CTRL_CHAN_TUNING_IN1: rd_data_d[TERM_MSB:TERM_LSB] = back_control_link_term_q;
          OFF_FWD_CHAN_IMPEDANCE:   rd_data_d = second_serial_input_impedance_q;
          OFF_INPUT_SELECTION:
          begin
            rd_data_d[SEL_OVR_BIT]  = sel_ovr_q;
            rd_data_d[SEL_CHAN_BIT] = sel_chan_q;
          end
          OFF_EQ_TEST_MODE:         rd_data_d[EQ_BYPASS_BIT] = eq_bypass_q;
          OFF_EQ_LEVEL:             rd_data_d[EQ_LEVEL_MSB:EQ_LEVEL_LSB] = eq_level_q;
          default:                  ;
        endcase
      end
    end
    // channel 0 while held down so the link starts from a known input
    if (held_down)
      active_channel_d = SEL_CHAN_RST;
    else if (sel_ovr_q)
      active_channel_d = sel_chan_q;
    else
      active_channel_d = select_pin;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sel_ovr_q                       <= SEL_OVR_RST;
      sel_chan_q                      <= SEL_CHAN_RST;
      eq_bypass_q                     <= EQ_BYPASS_RST;
      second_serial_input_impedance_q <= IMPEDANCE_RST;
      back_control_link_term_q        <= TERM_RST;
      active_channel_q                <= SEL_CHAN_RST;
      rd_data_q                       <= READ_ZERO;
      rd_valid_q                      <= 1'b0;
    end
    else
    begin
      sel_ovr_q                       <= sel_ovr_d;
      sel_chan_q                      <= sel_chan_d;
      eq_bypass_q                     <= eq_bypass_d;
      second_serial_input_impedance_q <= impedance_d;
      back_control_link_term_q        <= term_d;
      active_channel_q                <= active_channel_d;
      rd_data_q                       <= rd_data_d;
      rd_valid_q                      <= rd_valid_d;
    end
  end

  // ------------------------------------------------------------
  // applied equalizer level
  // ------------------------------------------------------------
  // bypass register feeds the tracker so manual takes over one cycle after the bypass bit is stored
  eq_level_track u_eq_level_track
  (
    .mclk            (mclk),
    .sys_rst         (sys_rst),
    .clear           (held_down),
    .bypass          (eq_bypass_q),
    .manual_level    (manual_eq_level),
    .adaptive        (adaptive_status),
    .applied_level_q (eq_level_q),
    .restart_q       (eq_restart_q)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_impedance_store: assert property (@(posedge mclk) disable iff (sys_rst)
    (power_down_pin && reg_req.wr && reg_req.addr == OFF_FWD_CHAN_IMPEDANCE)
      |=> second_serial_input_impedance_q == $past(reg_req.wdata))
    else $error("impedance code not stored");

  a_pin_select: assert property (@(posedge mclk) disable iff (sys_rst)
    (power_down_pin && !sel_ovr_q) |=> active_channel_q == $past(select_pin))
    else $error("active input does not follow select pin");

  a_override_select: assert property (@(posedge mclk) disable iff (sys_rst)
    (power_down_pin && sel_ovr_q) |=> active_channel_q == $past(sel_chan_q))
    else $error("active input does not follow channel bit");

  a_chan_reset: assert property (@(posedge mclk) disable iff (sys_rst)
    !power_down_pin |=> !sel_chan_q && !sel_ovr_q && !active_channel_q)
    else $error("channel select not cleared in power down");

  a_bypass_manual: assert property (@(posedge mclk) disable iff (sys_rst)
    (power_down_pin && eq_bypass_q) |=> eq_level_q == $past(manual_eq_level))
    else $error("manual level not applied in bypass");

  a_level_readback: assert property (@(posedge mclk) disable iff (sys_rst)
    (power_down_pin && reg_req.rd && reg_req.addr == OFF_EQ_LEVEL)
      |=> rd_valid_q && rd_data_q == {$past(eq_level_q), 4'h0})
    else $error("level readback wrong");

  a_lock_restart: assert property (@(posedge mclk) disable iff (sys_rst)
    (power_down_pin && $fell(adaptive_status.locked)) |=> eq_restart_q)
    else $error("no restart after lock loss");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    (reg_req.rd && reg_req.addr == OFF_INPUT_SELECTION) |=> rd_data_q[5:0] == 6'h00)
    else $error("reserved bits not zero");

  a_impedance_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    !power_down_pin |=> second_serial_input_impedance_q == IMPEDANCE_RST)
    else $error("impedance code not cleared in power down");

  a_bypass_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    !power_down_pin |=> !eq_bypass_q)
    else $error("bypass bit not cleared in power down");

  a_level_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    !power_down_pin |=> eq_level_q == EQ_LEVEL_RST)
    else $error("applied level not cleared in power down");

  a_adaptive_level: assert property (@(posedge mclk) disable iff (sys_rst)
    (power_down_pin && !eq_bypass_q && adaptive_status.locked)
      |=> eq_level_q == $past(adaptive_status.level))
    else $error("adaptive level not applied");

  a_unlock_level: assert property (@(posedge mclk) disable iff (sys_rst)
    (power_down_pin && !eq_bypass_q && !adaptive_status.locked) |=> eq_level_q == EQ_LEVEL_RST)
    else $error("level not restarted while unlocked");

  a_restart_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
    eq_restart_q |=> !eq_restart_q)
    else $error("restart longer than one cycle");

  a_term_read: assert property (@(posedge mclk) disable iff (sys_rst)
    (power_down_pin && reg_req.rd && reg_req.addr == OFF_CTRL_CHAN_TUNING_IN1)
      |=> rd_valid_q && rd_data_q == {4'h0, $past(back_control_link_term_q), 2'h0})
    else $error("termination readback wrong");

  a_test_mode_read: assert property (@(posedge mclk) disable iff (sys_rst)
    (power_down_pin && reg_req.rd && reg_req.addr == OFF_EQ_TEST_MODE)
      |=> rd_valid_q && rd_data_q == {1'b0, $past(eq_bypass_q), 6'h00})
    else $error("test mode readback wrong");

endmodule // input_select_eq_control

// ===== src/sel_eq_pkg.sv
//----------------------------------------------------------------------
// Purpose: shared constants and carriers for input selection and
//          equalizer control registers
// Assumes: 8-bit register offsets and 8-bit data
// Notes:   all offsets and field positions are named here
//----------------------------------------------------------------------
package sel_eq_pkg;

  // --------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL_CHAN_TUNING_IN1 = 8'h46;
  localparam logic [7:0] OFF_FWD_CHAN_IMPEDANCE   = 8'h47;
  localparam logic [7:0] OFF_INPUT_SELECTION      = 8'h4C;
  localparam logic [7:0] OFF_EQ_TEST_MODE         = 8'h4D;
  localparam logic [7:0] OFF_EQ_LEVEL             = 8'h4E;
  // manual level register lives elsewhere; its offset only for reference
  localparam logic [7:0] OFF_MANUAL_EQ            = 8'h04;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int TERM_LSB       = 2;
  localparam int TERM_MSB       = 3;
  localparam int SEL_OVR_BIT    = 7;
  localparam int SEL_CHAN_BIT   = 6;
  localparam int EQ_BYPASS_BIT  = 6;
  localparam int EQ_LEVEL_LSB   = 4;
  localparam int EQ_LEVEL_MSB   = 7;

  // --------------------------------------------------------------
  // reset values and other fixed codes
  // --------------------------------------------------------------
  localparam logic [1:0] TERM_RST       = 2'h0;
  localparam logic [7:0] IMPEDANCE_RST  = 8'h00;
  localparam logic [7:0] IMPEDANCE_LONG = 8'h70;
  localparam logic       SEL_OVR_RST    = 1'b0;
  localparam logic       SEL_CHAN_RST   = 1'b0;
  localparam logic       EQ_BYPASS_RST  = 1'b0;
  localparam logic [3:0] EQ_LEVEL_RST   = 4'h0;
  localparam logic [3:0] EQ_LEVEL_MAX   = 4'hF;
  localparam logic [7:0] READ_ZERO      = 8'h00;

  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic       locked;
    logic [3:0] level;
  } eq_status_s;

endpackage

// ===== src/eq_level_track.sv
//----------------------------------------------------------------------
// Purpose: picks the equalizer level applied and restarts adaption
// Assumes: adaptive level arrives as a thermometer code
// Notes:   level reads zero while the link is unlocked and adaptive
//----------------------------------------------------------------------
`timescale 1ns/1ps
module eq_level_track
  import sel_eq_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic                   clear,
  input  wire logic                   bypass,
  input  wire logic [3:0]             manual_level,
  input  wire sel_eq_pkg::eq_status_s adaptive,
  output logic [3:0]                  applied_level_q,
  output logic                        restart_q
);

  logic [3:0] applied_level_d;
  logic       restart_d;
  logic       lock_prev_q;
  logic       lock_prev_d;

  always_comb
  begin
    lock_prev_d     = adaptive.locked;
    // a lock drop forces the adaptive loop to start over
    restart_d       = lock_prev_q && !adaptive.locked && !clear;
    // lock history keeps tracking in power down so a drop right after release still restarts
    if (clear)
    begin
      applied_level_d = EQ_LEVEL_RST;
    end
    else if (bypass)
      applied_level_d = manual_level;
    else if (!adaptive.locked)
      applied_level_d = EQ_LEVEL_RST;
    else
      applied_level_d = adaptive.level;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      applied_level_q <= EQ_LEVEL_RST;
      restart_q       <= 1'b0;
      lock_prev_q     <= 1'b0;
    end
    else
    begin
      applied_level_q <= applied_level_d;
      restart_q       <= restart_d;
      lock_prev_q     <= lock_prev_d;
    end
  end

endmodule // eq_level_track

// ===== test/link_partner.sv
// Purpose: far-end serializer seen through the adaptive equalizer
// Assumes: lock follows link_up one edge later
// Notes:   level is garbage while unlocked, never the last value
`timescale 1ns/1ps
module link_partner
  import sel_eq_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             link_up,
  input  wire logic [3:0]       level,
  output sel_eq_pkg::eq_status_s status
);
  // ------------------------------------------------------------
  // lock and level
  // ------------------------------------------------------------
  // inverted level while unlocked so a design that ignores lock is caught
  always_ff @(posedge mclk)
  begin
    status <= '{locked: link_up, level: link_up ? level : ~level};
  end
endmodule // link_partner

// ===== test/testbench.sv
// Purpose: self-checking bench for input select and equalizer control
// Assumes: one access per cycle, reads answer one cycle later
// Notes:   inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module testbench;
  import sel_eq_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic       mclk = 0, sys_rst = 1, power_down_pin = 0, select_pin = 0;
  logic       link_up = 0, rd_valid_q, active_channel_q, eq_bypass_q, eq_restart_q;
  logic [3:0] level = 4'h0, manual_eq_level = 4'h0, eq_level_q;
  logic [7:0] rd_data_q, imp_q;
  logic [1:0] term_q;
  reg_req_s   req = '0;
  eq_status_s adaptive_status;
  int         num_errors = 0, checks_done = 0, restarts = 0;
  always #4 mclk = ~mclk;
  always @(posedge mclk) if (eq_restart_q === 1'b1) restarts++;
  link_partner link_partner_i (.mclk(mclk), .link_up(link_up), .level(level), .status(adaptive_status));
  input_select_eq_control input_select_eq_control_i (.mclk(mclk), .sys_rst(sys_rst),
    .power_down_pin(power_down_pin), .select_pin(select_pin), .reg_req(req),
    .manual_eq_level(manual_eq_level), .adaptive_status(adaptive_status), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .active_channel_q(active_channel_q),
    .second_serial_input_impedance_q(imp_q), .back_control_link_term_q(term_q),
    .eq_bypass_q(eq_bypass_q), .eq_level_q(eq_level_q), .eq_restart_q(eq_restart_q));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1 req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge mclk) #1 req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic v);
    @(posedge mclk) #1 req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(posedge mclk) #1 req = '0;
    chk({7'h00, rd_valid_q}, {7'h00, v});
    chk(rd_data_q, v ? e : 8'h00);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd(8'h46, 8'h00, 1'h1);
    rd(8'h47, 8'h00, 1'h1);
    rd(8'h4C, 8'h00, 1'h1);
    rd(8'h4D, 8'h00, 1'h1);
    rd(8'h4E, 8'h00, 1'h1);
  endtask
  task automatic t_impedance;
    wr(8'h47, 8'h70);
    rd(8'h47, 8'h70, 1'h1);
    chk(imp_q, 8'h70);
    wr(8'h47, 8'hA5);
    rd(8'h47, 8'hA5, 1'h1);
  endtask
  task automatic t_reserved;
    wr(8'h46, 8'hFF);
    rd(8'h46, 8'h0C, 1'h1);
    chk({6'h00, term_q}, 8'h03);
    wr(8'h4D, 8'hBF);
    rd(8'h4D, 8'h00, 1'h1);
    wr(8'h4E, 8'hFF);
    rd(8'h4E, 8'h00, 1'h1);
    rd(8'h48, 8'h00, 1'h1);
  endtask
  task automatic t_select;
    select_pin = 1'h1;
    tick(2);
    chk({7'h00, active_channel_q}, 8'h01);
    wr(8'h4C, 8'hFF);
    rd(8'h4C, 8'hC0, 1'h1);
    select_pin = 1'h0;
    tick(2);
    chk({7'h00, active_channel_q}, 8'h01);
    select_pin = 1'h1;
    wr(8'h4C, 8'h80);
    tick(1);
    chk({7'h00, active_channel_q}, 8'h00);
    wr(8'h4C, 8'h40);
    select_pin = 1'h0;
    tick(2);
    chk({7'h00, active_channel_q}, 8'h00);
  endtask
  task automatic t_equalizer;
    link_up = 1'h1;
    level = 4'h7;
    tick(3);
    rd(8'h4E, 8'h70, 1'h1);
    manual_eq_level = 4'h3;
    wr(8'h4D, 8'h40);
    level = 4'h1;
    tick(3);
    chk({eq_bypass_q, 3'h0, eq_level_q}, 8'h83);
    rd(8'h4E, 8'h30, 1'h1);
    level = 4'hF;
    wr(8'h4D, 8'h00);
    tick(2);
    rd(8'h4E, 8'hF0, 1'h1);
    restarts = 0;
    // non-zero level behind the drop so an ignored lock shows up
    level = 4'h3;
    link_up = 1'h0;
    tick(4);
    chk(8'(restarts), 8'h01);
    rd(8'h4E, 8'h00, 1'h1);
  endtask
  task automatic t_power_down;
    wr(8'h47, 8'h70);
    wr(8'h4C, 8'hC0);
    power_down_pin = 1'h0;
    tick(2);
    chk({imp_q[6:0], active_channel_q}, 8'h00);
    rd(8'h47, 8'h00, 1'h0);
    wr(8'h47, 8'h55);
    power_down_pin = 1'h1;
    rd(8'h47, 8'h00, 1'h1);
    wr(8'h47, 8'h70);
    sys_rst = 1'h1;
    tick(1);
    sys_rst = 1'h0;
    rd(8'h47, 8'h00, 1'h1);
  endtask
  // ------------------------------------------------------------
  // sequence and verdict
  // ------------------------------------------------------------
  task automatic print_verdict;
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #20us;
    num_errors++;
    print_verdict();
  end
  initial
  begin
    tick(4);
    sys_rst = 1'h0;
    // host releases power down only once supplies are up
    power_down_pin = 1'h1;
    t_reset();
    t_impedance();
    t_reserved();
    t_select();
    t_equalizer();
    t_power_down();
    print_verdict();
  end
endmodule // testbench
